/* design/pins_pkg.sv */
/*
 * Shared constants for the host pin function block: register map, field
 * positions, pin numbers, serial rates and voice port timing.
 * Assumes a 200 MHz system clock.
 */
package pins_pkg;
  localparam int CLK_HZ = 200_000_000;

  // Register byte offsets.
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_TXDATA = 6'h08;
  localparam logic [5:0] REG_RXDATA = 6'h0c;
  localparam logic [5:0] REG_PCM_TX = 6'h10;
  localparam logic [5:0] REG_PCM_RX = 6'h14;
  localparam logic [5:0] REG_CODEC = 6'h18;

  // Control register fields and reset value (9600 baud, 8N1).
  localparam int CTL_CODEC = 0;
  localparam int CTL_USB_RDY = 1;
  localparam int CTL_RATE = 2;
  localparam int CTL_DATA8 = 5;
  localparam int CTL_PAR = 6;
  localparam int CTL_STOP2 = 8;
  localparam logic [8:0] CTRL_RST = 9'h020;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;

  // Status register fields.
  localparam int ST_USB = 0;
  localparam int ST_VBUS = 1;
  localparam int ST_TXBUSY = 2;
  localparam int ST_RXFULL = 3;
  localparam int ST_PERR = 4;
  localparam int ST_FERR = 5;
  localparam int ST_PCMF = 6;

  // General-purpose pin numbers.
  localparam int PIN_CCC = 0;
  localparam int PIN_CSE = 1;
  localparam int PIN_PULLUP = 2;
  localparam int PIN_VBUS = 3;
  localparam int PIN_CCD = 6;
  localparam int PIN_FSYNC = 7;
  localparam int PIN_PCM_IN = 8;
  localparam int PIN_BCLK = 9;
  localparam int PIN_PCM_OUT = 10;
  localparam int PIN_USB_SEL = 15;

  // Voice port timing.
  localparam int BCLK_HZ = 1_000_000;
  localparam int FRAME_HZ = 8_000;
  localparam int DUTY_PCT = 5;
  localparam int BCLK_CYC = CLK_HZ / BCLK_HZ;
  localparam int BCLK_HI = BCLK_CYC * DUTY_PCT / 100;
  localparam int SAMPLE_AT = BCLK_CYC / 2;
  localparam int FRAME_BITS = BCLK_HZ / FRAME_HZ;
  localparam int SAMPLE_W = 14;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} rx_state_t;

  // Clock cycles per serial bit for each rate selector.
  function automatic logic [15:0] bit_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: return 16'(CLK_HZ / 9600);
      3'h1: return 16'(CLK_HZ / 19200);
      3'h2: return 16'(CLK_HZ / 38400);
      3'h3: return 16'(CLK_HZ / 57600);
      3'h4: return 16'(CLK_HZ / 115200);
      3'h5: return 16'(CLK_HZ / 230400);
      3'h6: return 16'(CLK_HZ / 460800);
      default: return 16'(CLK_HZ / 921600);
    endcase
  endfunction : bit_cycles

  // Bits in one character: start, data, optional parity, stop.
  function automatic logic [3:0] frame_len(input logic [8:0] c);
    return 4'd1 + (c[CTL_DATA8] ? 4'd8 : 4'd7) + ((c[7:6] != PAR_NONE) ? 4'd1 : 4'd0)
      + (c[CTL_STOP2] ? 4'd2 : 4'd1);
  endfunction : frame_len

  function automatic logic par_bit(input logic [7:0] d, input logic [8:0] c);
    logic p;
    p = c[CTL_DATA8] ? ^d : ^d[6:0];
    return (c[7:6] == PAR_ODD) ? ~p : p;
  endfunction : par_bit
endpackage : pins_pkg

/* design/pcm_if.sv */
/*
 * Link between the register side and the voice port generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pcm_if;
  logic en;
  logic din;
  logic [13:0] tx_sample;
  logic [13:0] rx_sample;
  logic frame;
  logic bclk;
  logic fsync;
  logic dout;
  modport ctl (output en, din, tx_sample, input rx_sample, frame, bclk, fsync, dout);
  modport port (input en, din, tx_sample, output rx_sample, frame, bclk, fsync, dout);
endinterface : pcm_if
`default_nettype wire

/* design/pcm_port.sv */
/*
 * Voice port timing master: bit clock, frame sync and 14-bit sample shifting.
 * Assumes din is already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pcm_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Control side.
  pcm_if.port p
);
  logic [7:0] cyc, next_cyc;
  logic [6:0] bitn, next_bitn;
  logic [13:0] tx_lat, next_tx_lat, rx_sh, next_rx_sh, next_rx_sample;
  logic next_bclk, next_fsync, next_dout, next_frame;

  always_comb begin
    next_cyc = cyc;
    next_bitn = bitn;
    next_tx_lat = tx_lat;
    next_rx_sh = rx_sh;
    next_rx_sample = p.rx_sample;
    next_frame = 1'b0;
    next_bclk = 1'b0;
    next_fsync = 1'b0;
    next_dout = 1'b0;
    if (!p.en) begin
      next_cyc = 8'(pins_pkg::BCLK_CYC - 1);
      next_bitn = 7'(pins_pkg::FRAME_BITS - 1);
    end else begin
      if (cyc == 8'(pins_pkg::BCLK_CYC - 1)) begin
        next_cyc = 8'h00;
        next_bitn = (bitn == 7'(pins_pkg::FRAME_BITS - 1)) ? 7'h00 : bitn + 7'h01;
      end else begin
        next_cyc = cyc + 8'h01;
      end
      next_bclk = next_cyc < 8'(pins_pkg::BCLK_HI);
      next_fsync = next_bitn == 7'h00;
      if (next_bitn == 7'h00) begin
        next_tx_lat = p.tx_sample;
      end
      if (next_bitn >= 7'h01 && next_bitn <= 7'(pins_pkg::SAMPLE_W)) begin
        next_dout = next_tx_lat[4'(7'(pins_pkg::SAMPLE_W) - next_bitn)];
      end
      if (cyc == 8'(pins_pkg::SAMPLE_AT) && bitn >= 7'h01 && bitn <= 7'(pins_pkg::SAMPLE_W)) begin
        next_rx_sh = {rx_sh[12:0], p.din};
        if (bitn == 7'(pins_pkg::SAMPLE_W)) begin
          next_rx_sample = next_rx_sh;
          next_frame = 1'b1;
        end
      end
    end
  end

  // clock and sync are generated here.
  always_ff @(posedge clk) begin
    if (srst) begin
      cyc <= 8'(pins_pkg::BCLK_CYC - 1);
      bitn <= 7'(pins_pkg::FRAME_BITS - 1);
      tx_lat <= 14'h0000;
      rx_sh <= 14'h0000;
      p.rx_sample <= 14'h0000;
      p.frame <= 1'b0;
      p.bclk <= 1'b0;
      p.fsync <= 1'b0;
      p.dout <= 1'b0;
    end else begin
      cyc <= next_cyc;
      bitn <= next_bitn;
      tx_lat <= next_tx_lat;
      rx_sh <= next_rx_sh;
      p.rx_sample <= next_rx_sample;
      p.frame <= next_frame;
      p.bclk <= next_bclk;
      p.fsync <= next_fsync;
      p.dout <= next_dout;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_bclk_duty;
    $rose(p.bclk) |-> p.bclk[*8] ##1 p.bclk[*2] ##1 !p.bclk;
  endproperty
  a_bclk_duty: assert property (p_bclk_duty) else $error("bit clock high time wrong");

  property p_bclk_period;
    $rose(p.bclk) && p.en |-> ##200 ($rose(p.bclk) || !p.en);
  endproperty
  a_bclk_period: assert property (p_bclk_period) else $error("bit clock period wrong");

  property p_sync_bit0;
    p.fsync |-> (bitn == 7'h00) && p.en;
  endproperty
  a_sync_bit0: assert property (p_sync_bit0) else $error("sync outside bit zero");

  property p_dout_slot;
    (bitn == 7'h00 || bitn > 7'd14) |-> !p.dout;
  endproperty
  a_dout_slot: assert property (p_dout_slot) else $error("data outside sample slot");

  c_frame: cover property (p.frame);
endmodule : pcm_port
`default_nettype wire

/* design/host_pin_functions.sv */
/*
 * Host-side pin functions: reset pin, serial port with flow control,
 * USB mode pins, codec control pins and voice port, under Avalon-MM registers.
 * Assumes pins are asynchronous to clk; registers use a single bus master.
 */
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module host_pin_functions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Active-low reset pin.
  input wire logic reset_pin_n,
  // Avalon-MM register slave.
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial port.
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n,
  // General-purpose pins.
  input wire logic [15:0] gpio_in,
  output logic [15:0] gpio_out,
  output logic [15:0] gpio_oe
);
  localparam int SY_RST = 0;
  localparam int SY_TXD = 1;
  localparam int SY_RTS = 2;
  localparam int SY_VBUS = 3;
  localparam int SY_PIN = 4;
  localparam int SY_USB = 5;
  localparam logic [5:0] SYNC_RST = 6'h06;

  logic [5:0] sync1, sync2;
  logic srst, txd_s, rts_s, usb_mode;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {gpio_in[pins_pkg::PIN_USB_SEL], gpio_in[pins_pkg::PIN_PCM_IN],
                gpio_in[pins_pkg::PIN_VBUS], rts_n, txd, reset_pin_n};
      sync2 <= sync1;
    end
  end

  assign srst = rst | ~sync2[SY_RST];
  assign txd_s = sync2[SY_TXD];
  assign rts_s = sync2[SY_RTS];
  assign usb_mode = sync2[SY_USB];

  pcm_if pcm ();
  pcm_port u_pcm (
    .clk(clk),
    .srst(srst),
    .p(pcm.port)
  );

  // Register bus.
  logic [8:0] ctrl, next_ctrl;
  logic [2:0] codec, next_codec;
  logic [13:0] pcm_tx, next_pcm_tx;
  logic next_wait, tx_load, rx_take, pcm_take, tx_busy;
  logic [31:0] next_rdata, rmux, st;
  logic tx_pend, rx_full, perr, ferr, pcm_flag;
  logic [3:0] tx_left;
  logic [7:0] rx_data;

  always_comb begin
    st = 32'h0;
    st[pins_pkg::ST_USB] = usb_mode;
    st[pins_pkg::ST_VBUS] = usb_mode & sync2[SY_VBUS];
    st[pins_pkg::ST_TXBUSY] = tx_busy;
    st[pins_pkg::ST_RXFULL] = rx_full;
    st[pins_pkg::ST_PERR] = perr;
    st[pins_pkg::ST_FERR] = ferr;
    st[pins_pkg::ST_PCMF] = pcm_flag;
    if (address == pins_pkg::REG_CTRL) begin
      rmux = {23'h0, ctrl};
    end else if (address == pins_pkg::REG_STATUS) begin
      rmux = st;
    end else if (address == pins_pkg::REG_RXDATA) begin
      rmux = {24'h0, rx_data};
    end else if (address == pins_pkg::REG_PCM_TX) begin
      rmux = {18'h0, pcm_tx};
    end else if (address == pins_pkg::REG_PCM_RX) begin
      rmux = {18'h0, pcm.rx_sample};
    end else if (address == pins_pkg::REG_CODEC) begin
      rmux = {29'h0, codec};
    end else begin
      rmux = 32'h0;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    next_codec = codec;
    next_pcm_tx = pcm_tx;
    next_wait = 1'b1;
    next_rdata = readdata;
    tx_load = 1'b0;
    rx_take = 1'b0;
    pcm_take = 1'b0;
    if ((read || write) && waitrequest) begin
      next_wait = 1'b0;
      next_rdata = read ? rmux : 32'h0;
    end
    if (write && !waitrequest) begin
      if (address == pins_pkg::REG_CTRL) begin
        next_ctrl = writedata[8:0];
      end else if (address == pins_pkg::REG_TXDATA) begin
        tx_load = !tx_busy;
      end else if (address == pins_pkg::REG_PCM_TX) begin
        next_pcm_tx = writedata[13:0];
      end else if (address == pins_pkg::REG_CODEC) begin
        next_codec = writedata[2:0];
      end
    end
    if (read && !waitrequest) begin
      rx_take = address == pins_pkg::REG_RXDATA;
      pcm_take = address == pins_pkg::REG_PCM_RX;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= pins_pkg::CTRL_RST;
      codec <= 3'h0;
      pcm_tx <= 14'h0000;
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      codec <= next_codec;
      pcm_tx <= next_pcm_tx;
      waitrequest <= next_wait;
      readdata <= next_rdata;
    end
  end

  // Serial transmit toward the host on rxd.
  logic [7:0] tx_hold, next_hold;
  logic [11:0] tx_shift, next_shift, frm;
  logic [3:0] next_left, flen;
  logic [15:0] tx_cnt, next_tcnt, bc;
  logic next_pend, next_rxd;

  assign flen = pins_pkg::frame_len(ctrl);
  assign bc = pins_pkg::bit_cycles(ctrl[pins_pkg::CTL_RATE +: 3]);
  assign tx_busy = tx_pend | (tx_left != 4'h0);

  always_comb begin
    frm = 12'hfff;
    frm[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || ctrl[pins_pkg::CTL_DATA8]) begin
        frm[i + 1] = tx_hold[i];
      end
    end
    if (ctrl[7:6] != pins_pkg::PAR_NONE) begin
      frm[ctrl[pins_pkg::CTL_DATA8] ? 9 : 8] = pins_pkg::par_bit(tx_hold, ctrl);
    end
  end

  always_comb begin
    next_hold = tx_hold;
    next_pend = tx_pend;
    next_shift = tx_shift;
    next_left = tx_left;
    next_tcnt = tx_cnt;
    if (tx_load) begin
      next_hold = writedata[7:0];
      next_pend = 1'b1;
    end
    if (tx_left != 4'h0) begin
      if (tx_cnt == 16'h1) begin
        next_shift = {1'b1, tx_shift[11:1]};
        next_left = tx_left - 4'h1;
        next_tcnt = bc;
      end else begin
        next_tcnt = tx_cnt - 16'h1;
      end
    // start only while the host asserts rts.
    end else if (tx_pend && !rts_s) begin
      next_shift = frm;
      next_left = flen;
      next_tcnt = bc;
      next_pend = 1'b0;
    end
    next_rxd = (next_left != 4'h0) ? next_shift[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_hold <= 8'h00;
      tx_pend <= 1'b0;
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt <= 16'h0;
      rxd <= 1'b1;
    end else begin
      tx_hold <= next_hold;
      tx_pend <= next_pend;
      tx_shift <= next_shift;
      tx_left <= next_left;
      tx_cnt <= next_tcnt;
      rxd <= next_rxd;
    end
  end

  // Serial receive from the host on txd.
  pins_pkg::rx_state_t rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rcnt;
  logic [3:0] rx_bits, next_bits;
  logic [10:0] rx_sh, next_rsh, aligned;
  logic [7:0] next_rdat;
  logic next_full, next_perr, next_ferr, next_pflag;

  always_comb begin
    next_rx_st = rx_st;
    next_rcnt = rx_cnt;
    next_bits = rx_bits;
    next_rsh = rx_sh;
    next_rdat = rx_data;
    aligned = 11'h0;
    // Set wins over a clear by reading the data register.
    next_full = rx_full & ~rx_take;
    next_perr = perr & ~rx_take;
    next_ferr = ferr & ~rx_take;
    next_pflag = pcm.frame | (pcm_flag & ~pcm_take);
    case (rx_st)
      pins_pkg::RX_IDLE: begin
        if (!txd_s) begin
          next_rcnt = bc >> 1;
          next_rx_st = pins_pkg::RX_START;
        end
      end
      pins_pkg::RX_START: begin
        if (rx_cnt == 16'h1) begin
          next_rx_st = txd_s ? pins_pkg::RX_IDLE : pins_pkg::RX_DATA;
          next_rcnt = bc;
          next_bits = flen - 4'h1;
        end else begin
          next_rcnt = rx_cnt - 16'h1;
        end
      end
      pins_pkg::RX_DATA: begin
        if (rx_cnt == 16'h1) begin
          next_rsh = {txd_s, rx_sh[10:1]};
          next_rcnt = bc;
          next_bits = rx_bits - 4'h1;
          if (rx_bits == 4'h1) begin
            next_rx_st = pins_pkg::RX_IDLE;
            aligned = next_rsh >> (4'd12 - flen);
            next_rdat = ctrl[pins_pkg::CTL_DATA8] ? aligned[7:0] : {1'b0, aligned[6:0]};
            next_full = 1'b1;
            if (ctrl[7:6] != pins_pkg::PAR_NONE
                && aligned[ctrl[pins_pkg::CTL_DATA8] ? 8 : 7] != pins_pkg::par_bit(next_rdat, ctrl)) begin
              next_perr = 1'b1;
            end
            if (!aligned[4'(flen - 4'h2)]) begin
              next_ferr = 1'b1;
            end
          end
        end else begin
          next_rcnt = rx_cnt - 16'h1;
        end
      end
      default: next_rx_st = pins_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st <= pins_pkg::RX_IDLE;
      rx_cnt <= 16'h0;
      rx_bits <= 4'h0;
      rx_sh <= 11'h0;
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
      pcm_flag <= 1'b0;
      cts_n <= 1'b1;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rcnt;
      rx_bits <= next_bits;
      rx_sh <= next_rsh;
      rx_data <= next_rdat;
      rx_full <= next_full;
      perr <= next_perr;
      ferr <= next_ferr;
      pcm_flag <= next_pflag;
      // cts driven, high while data waits.
      cts_n <= next_full;
    end
  end

  // Pin functions.
  logic [15:0] next_gout, next_goe;
  logic codec_en;

  assign codec_en = ctrl[pins_pkg::CTL_CODEC];
  assign pcm.en = codec_en;
  assign pcm.din = sync2[SY_PIN];
  assign pcm.tx_sample = pcm_tx;

  always_comb begin
    next_gout = 16'h0;
    next_goe = 16'h0;
    next_goe[pins_pkg::PIN_CCC] = codec_en;
    next_goe[pins_pkg::PIN_CSE] = codec_en;
    next_goe[pins_pkg::PIN_CCD] = codec_en;
    next_gout[pins_pkg::PIN_CCC] = codec_en & codec[0];
    next_gout[pins_pkg::PIN_CSE] = codec_en & codec[1];
    next_gout[pins_pkg::PIN_CCD] = codec_en & codec[2];
    // voice pins, clock and sync driven out.
    next_goe[pins_pkg::PIN_FSYNC] = codec_en;
    next_goe[pins_pkg::PIN_BCLK] = codec_en;
    next_goe[pins_pkg::PIN_PCM_OUT] = codec_en;
    next_gout[pins_pkg::PIN_FSYNC] = pcm.fsync;
    next_gout[pins_pkg::PIN_BCLK] = pcm.bclk;
    next_gout[pins_pkg::PIN_PCM_OUT] = pcm.dout;
    next_goe[pins_pkg::PIN_PULLUP] = usb_mode;
    next_gout[pins_pkg::PIN_PULLUP] = usb_mode & ctrl[pins_pkg::CTL_USB_RDY];
  end

  // inputs and low pull-up at reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      gpio_out <= 16'h0;
      gpio_oe <= 16'h0;
    end else begin
      gpio_out <= next_gout;
      gpio_oe <= next_goe;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_reset_all;
    disable iff (1'b0) srst |=> ctrl == pins_pkg::CTRL_RST && gpio_oe == 16'h0 && rxd;
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("reset did not clear state");

  property p_wait_answer;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("waitrequest sequence wrong");

  property p_tx_hold_rts;
    rts_s && tx_left == 4'h0 |=> tx_left == 4'h0;
  endproperty
  a_tx_hold_rts: assert property (p_tx_hold_rts) else $error("sent without rts");

  property p_rxd_idle;
    tx_left == 4'h0 |=> rxd || tx_left != 4'h0;
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) else $error("rxd low while idle");

  property p_cts_full;
    $rose(rx_full) |-> cts_n;
  endproperty
  a_cts_full: assert property (p_cts_full) else $error("cts not raised when full");

  property p_pullup;
    !usb_mode ##1 !usb_mode |-> !gpio_out[pins_pkg::PIN_PULLUP];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up outside USB mode");

  property p_codec_oe;
    !codec_en ##1 !codec_en |-> gpio_oe[pins_pkg::PIN_BCLK] == 1'b0;
  endproperty
  a_codec_oe: assert property (p_codec_oe) else $error("voice pins driven when off");

  c_rx_char: cover property ($rose(rx_full));
  c_enum: cover property (gpio_out[pins_pkg::PIN_PULLUP]);
  c_tx_start: cover property ($rose(tx_left != 4'h0));
endmodule : host_pin_functions
`default_nettype wire

/* testbench/host_partner.sv */
/* Far-side model: a serial host and a voice codec.
   Assumes the bench clock; the bench sets bc to clock cycles per bit. */
`timescale 1ns/1ps
`default_nettype none
module host_partner (
  // Clock.
  input wire logic clk,
  // Serial lines.
  input wire logic rxd,
  output logic txd,
  // Voice pins.
  input wire logic bclk,
  input wire logic fsync,
  input wire logic pcm_out,
  output logic pcm_in
);
  int bc = 217;
  int idx = 0;
  logic prev = 1'b0;
  logic [13:0] smp = 14'h2abc;
  logic [13:0] got = 14'h0;
  initial begin
    txd = 1'b1;
    pcm_in = 1'b1;
  end
  task automatic send(input logic [11:0] v, input int n);
    txd <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (bc) @(posedge clk);
      txd <= (i < n) ? v[i] : 1'b1;
    end
  endtask : send
  task automatic recv(output logic [11:0] v, input int n);
    int k;
    k = 0;
    v = 12'h0;
    while (rxd !== 1'b0 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge clk);
      v[i] = rxd;
    end
  endtask : recv
  // follows the clock, 14 bits msb first
  always @(posedge clk) begin
    prev <= bclk;
    if (bclk && !prev) begin
      idx = fsync ? 0 : idx + 1;
      pcm_in <= (idx >= 1 && idx <= 14) ? smp[14 - idx] : 1'b1;
    end
    if (!bclk && prev && idx >= 1 && idx <= 14)
      got[14 - idx] <= pcm_out;
  end
endmodule : host_partner
`default_nettype wire

/* testbench/host_pin_functions_tb.sv */
/* Self-checking bench: registers, serial port, USB and voice pins.
   Assumes host_partner on the serial and voice pins. */
`timescale 1ns/1ps
`default_nettype none
module host_pin_functions_tb;
  logic clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, read = 1'b0, write = 1'b0;
  logic [5:0] address = 6'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, txd, rxd, cts_n, pcm_in, rts_n = 1'b0, usb_sel = 1'b0, vbus = 1'b0;
  logic [15:0] gpio_in, gpio_out, gpio_oe;
  logic [11:0] e, v;
  logic [8:0] cfg [3] = '{9'h03c, 9'h15c, 9'h0b8};
  int rate [3] = '{921600, 921600, 460800};
  int error_cnt = 0, tests_run = 0, hi, per, n;
  assign gpio_in = {usb_sel, 6'h3f, pcm_in, 4'h0, vbus, 3'h0};
  initial begin
    forever #2.5 clk = ~clk;
  end
  host_pin_functions dut_u (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .txd(txd), .rts_n(rts_n),
    .rxd(rxd), .cts_n(cts_n), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  host_partner host_u (.clk(clk), .rxd(rxd), .txd(txd), .bclk(gpio_out[9]),
    .fsync(gpio_out[7]), .pcm_out(gpio_out[10]), .pcm_in(pcm_in));
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
    if (k >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask : bus
  task automatic meas(input int b, output int h, output int p);
    int k;
    k = 0;
    h = 0;
    while (gpio_out[b] !== 1'b1 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    while (gpio_out[b] === 1'b1 && h < 30000) begin
      @(posedge clk);
      h++;
    end
    p = h;
    while (gpio_out[b] === 1'b0 && p < 30000) begin
      @(posedge clk);
      p++;
    end
    if (k >= 30000 || h >= 30000 || p >= 30000) begin
      error_cnt++;
      complete_run();
    end
  endtask : meas
  function automatic logic [11:0] fr(input logic [7:0] d, input logic [8:0] c);
    logic [11:0] f;
    logic p;
    f = c[5] ? {4'h0, d} : {5'h0, d[6:0]};
    n = c[5] ? 8 : 7;
    p = c[5] ? ^d : ^d[6:0];
    if (c[7:6] != 2'h0) begin
      f[n] = (c[7:6] == 2'h2) ? ~p : p;
      n += 1;
    end
    f[n] = 1'b1;
    n += c[8] ? 2 : 1;
    return c[8] ? (f | (12'h1 << (n - 1))) : f;
  endfunction : fr
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(32'({gpio_oe, gpio_out[2], rxd, cts_n}), 32'h2);
    bus(0, 6'h00, 32'h0);
    chk(q, 32'h20);
    for (int i = 0; i < 3; i++) begin
      bus(1, 6'h00, 32'(cfg[i]));
      host_u.bc = 200_000_000 / rate[i];
      e = fr(8'hd3 + 8'(i), cfg[i]);
      rts_n <= 1'b1;
      bus(1, 6'h08, 32'(8'hd3 + 8'(i)));
      repeat (1000) @(posedge clk);
      chk(32'(rxd), 32'h1);
      bus(0, 6'h04, 32'h0);
      chk(32'(q[2]), 32'h1);
      rts_n <= 1'b0;
      host_u.recv(v, n);
      chk(32'(v), 32'(e));
      host_u.send(e, n);
      chk(32'(cts_n), 32'h1);
      bus(0, 6'h04, 32'h0);
      chk(32'(q[5:2]), 32'h2);
      bus(0, 6'h0c, 32'h0);
      chk(q, 32'(cfg[i][5] ? 8'hd3 + 8'(i) : 8'h53 + 8'(i)));
      chk(32'(cts_n), 32'h0);
    end
    host_u.send(e ^ 12'h100, n);
    bus(0, 6'h04, 32'h0);
    chk(32'(q[5:3]), 32'h3);
    bus(0, 6'h0c, 32'h0);
    usb_sel <= 1'b1;
    vbus <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, 6'h04, 32'h0);
    chk(32'(q[1:0]), 32'h3);
    chk(32'({gpio_oe[2], gpio_out[2]}), 32'h2);
    bus(1, 6'h00, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'(gpio_out[2]), 32'h1);
    usb_sel <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, 6'h04, 32'h0);
    chk(32'({q[1:0], gpio_oe[2], gpio_out[2]}), 32'h0);
    bus(1, 6'h18, 32'h5);
    bus(1, 6'h10, 32'h1357);
    bus(1, 6'h00, 32'h1);
    meas(7, hi, per);
    chk(32'(hi), 32'd200);
    chk(32'(per), 32'd25000);
    chk(32'(gpio_oe), 32'h06c3);
    chk(32'({gpio_out[6], gpio_out[1], gpio_out[0]}), 32'h5);
    meas(9, hi, per);
    chk(32'(hi), 32'd10);
    chk(32'(per), 32'd200);
    bus(0, 6'h04, 32'h0);
    chk(32'(q[6]), 32'h1);
    bus(0, 6'h14, 32'h0);
    chk(q, 32'h2abc);
    chk(32'(host_u.got), 32'h1357);
    // host reset pulse, kept short since the block only needs the sync delay.
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    bus(0, 6'h00, 32'h0);
    chk(32'({q[8:0], gpio_oe}), 32'h200000);
    complete_run();
  end
endmodule : host_pin_functions_tb
`default_nettype wire
